//--- core/sevr_pkg.sv
// shared constants and types of the status and event reporting block
package sevr_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int unsigned EVT_W = 8;

    // ****************************************
    // standard event register bit positions
    // ****************************************
    localparam int unsigned SE_POWER = 7;
    localparam int unsigned SE_CMD   = 5;
    localparam int unsigned SE_EXEC  = 4;
    localparam int unsigned SE_QUERY = 2;
    localparam int unsigned SE_DONE  = 0;

    // ****************************************
    // status byte bit positions
    // ****************************************
    localparam int unsigned SB_MEAS  = 0;
    localparam int unsigned SB_PROBE = 1;
    localparam int unsigned SB_MAV   = 4;
    localparam int unsigned SB_ESB   = 5;
    localparam int unsigned SB_MSS   = 6;

    // ****************************************
    // implemented bits and values after reset
    // ****************************************
    localparam logic [7:0] SE_VALID   = 8'hb5;
    localparam logic [7:0] MEAS_VALID = 8'h7f;
    localparam logic [7:0] PROBE_VALID = 8'h0f;
    localparam logic [7:0] SB_VALID   = 8'h33;
    localparam logic [7:0] SE_RST     = 8'h80;
    localparam logic [7:0] EVT_RST    = 8'h00;
    localparam logic [7:0] MASK_RST   = 8'h00;

    // ****************************************
    // remote and local control states
    // ****************************************
    typedef enum logic [3:0] {
        rl_local       = 4'b0001,
        rl_remote      = 4'b0010,
        rl_local_lock  = 4'b0100,
        rl_remote_lock = 4'b1000
    } sevr_rl_e;

endpackage

//--- core/sevr_event_reg.sv
// one clear-on-read event register with its enable mask
`timescale 1ns/1ps
module sevr_event_reg #(
    parameter int unsigned W     = 8,
    parameter logic [W-1:0] VALID = '1,
    parameter logic [W-1:0] RST   = '0,
    parameter logic [W-1:0] MRST  = '0
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    // events and clears
    input  wire logic [W-1:0] set_bits,
    input  wire logic         clear,
    // mask write
    input  wire logic         mask_we,
    input  wire logic [W-1:0] mask_wdata,
    // state
    output logic      [W-1:0] flags_q,
    output logic      [W-1:0] mask_q,
    output logic              summary
);
    logic [W-1:0] flags_d;
    logic [W-1:0] mask_d;

    // set wins over a clear in the same cycle
    assign flags_d = ((flags_q & ~{W{clear}}) | set_bits) & VALID;
    assign mask_d  = mask_we ? mask_wdata : mask_q;
    assign summary = |(flags_q & mask_q & VALID);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= RST;
            mask_q  <= MRST;
        end else begin
            flags_q <= flags_d;
            mask_q  <= mask_d;
        end
    end

    unused_bits_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (flags_q & ~VALID) == '0)
        else $error("unused event bit set");

    set_wins_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clear |=> flags_q == $past(set_bits & VALID))
        else $error("clear did not leave only new events");

endmodule

//--- core/sevr_iface_msg.sv
// bus interface messages: remote and local states, clears, trigger
`timescale 1ns/1ps
module sevr_iface_msg
    import sevr_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // interface messages
    input  wire logic gtl_msg,
    input  wire logic llo_msg,
    input  wire logic dcl_msg,
    input  wire logic sdc_msg,
    input  wire logic get_msg,
    // remote enable line and addressing
    input  wire logic remote_enter,
    input  wire logic ren_released,
    // front panel
    input  wire logic local_key,
    // results
    output logic      remote_q,
    output logic      keys_enable_q,
    output logic      local_key_enable_q,
    output logic      ibuf_clear_q,
    output logic      trigger_q
);
    sevr_rl_e rl_q;
    sevr_rl_e rl_d;

    always_comb begin
        rl_d = rl_q;
        case (rl_q)
            rl_local: begin
                if (llo_msg) rl_d = rl_local_lock;
                else if (remote_enter && !gtl_msg) rl_d = rl_remote;
            end
            rl_remote: begin
                if (llo_msg && gtl_msg) rl_d = rl_local_lock;
                else if (llo_msg) rl_d = rl_remote_lock;
                else if (gtl_msg || local_key) rl_d = rl_local;
            end
            rl_local_lock: begin
                if (remote_enter && !gtl_msg) rl_d = rl_remote_lock;
            end
            rl_remote_lock: begin
                // local key is dead here, only the controller frees it
                if (gtl_msg) rl_d = rl_local_lock;
            end
            default: rl_d = rl_local;
        endcase
        if (ren_released) rl_d = rl_local;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rl_q               <= rl_local;
            remote_q           <= 1'b0;
            keys_enable_q      <= 1'b1;
            local_key_enable_q <= 1'b0;
            ibuf_clear_q       <= 1'b0;
            trigger_q          <= 1'b0;
        end else begin
            rl_q               <= rl_d;
            remote_q           <= (rl_d == rl_remote) ||
                                  (rl_d == rl_remote_lock);
            keys_enable_q      <= (rl_d == rl_local);
            local_key_enable_q <= (rl_d == rl_remote);
            ibuf_clear_q       <= dcl_msg || sdc_msg;
            trigger_q          <= get_msg;
        end
    end

    gtl_to_local_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        gtl_msg |=> !remote_q)
        else $error("go to local left device remote");

    lockout_keys_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (llo_msg && !ren_released) |=> !keys_enable_q && !local_key_enable_q)
        else $error("keys still live after lockout");

    one_trigger_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        get_msg |=> trigger_q ##1 (trigger_q == $past(get_msg)))
        else $error("trigger not one sample per message");

endmodule

//--- core/sevr_top.sv
// status byte, event registers and interface message handling
//
// Contract
// - enabled standard events set status bit 5
// - standard events clear on clear, query, power-on
// - power-on or outage recovery sets bit 7
// - command error sets bit 5, skip to terminator
// - execution failure sets standard event bit 4
// - queue errors set bit 2, clear queue
// - operation complete sets bit 0 after prior work
// - enable mask bit passes matching event bit
// - two extra event registers with own masks
// - enabled device events set status bits 0, 1
// - device events clear on clear, own query
// - measurement events bits 6 to 0 mapped
// - probe fault events bits 3 to 0 mapped
// - events read-only, masks written and read
// - device clear empties input and output queues
// - group trigger runs exactly one sample
// - go to local leaves remote state
// - local lockout disables every front key
// - enabled status bits give summary and request
// - clear status spares message available bit
// - status bit 4 follows output queue data
`timescale 1ns/1ps
module sevr_top (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // power supervision
    input  wire logic       power_restored,
    // command parser events
    input  wire logic       cmd_error,
    input  wire logic       exec_error,
    input  wire logic       terminator_seen,
    input  wire logic       complete_cmd,
    input  wire logic       prior_done,
    input  wire logic       cls_cmd,
    // output queue status
    input  wire logic       oq_not_empty,
    input  wire logic       oq_read_empty,
    input  wire logic       oq_overflow,
    input  wire logic       oq_data_lost,
    input  wire logic       cmd_while_data,
    // measurement events
    input  wire logic       out_of_range_fault,
    input  wire logic       measurement_fault,
    input  wire logic       comparator_high,
    input  wire logic       comparator_in_band,
    input  wire logic       comparator_low,
    input  wire logic       conversion_done,
    input  wire logic       measurement_done,
    // probe fault events
    input  wire logic       voltage_monitor_fault,
    input  wire logic       current_monitor_fault,
    input  wire logic       contact_fault_high_side,
    input  wire logic       contact_fault_low_side,
    // register writes
    input  wire logic [7:0] wr_data,
    input  wire logic       sre_write,
    input  wire logic       standard_mask_write,
    input  wire logic       measurement_mask_write,
    input  wire logic       probe_fault_mask_write,
    // register queries
    input  wire logic       stb_query,
    input  wire logic       sre_query,
    input  wire logic       standard_event_query,
    input  wire logic       standard_mask_query,
    input  wire logic       measurement_event_query,
    input  wire logic       measurement_mask_query,
    input  wire logic       probe_fault_event_query,
    input  wire logic       probe_fault_mask_query,
    input  wire logic       serial_poll,
    // interface messages
    input  wire logic       gtl_msg,
    input  wire logic       llo_msg,
    input  wire logic       dcl_msg,
    input  wire logic       sdc_msg,
    input  wire logic       get_msg,
    input  wire logic       remote_enter,
    input  wire logic       ren_released,
    input  wire logic       local_key,
    // responses
    output logic      [7:0] resp_data_q,
    output logic            resp_valid_q,
    // status and service request
    output logic      [7:0] status_byte_q,
    output logic            srq_q,
    // queue and parser control
    output logic            oq_clear_q,
    output logic            ibuf_clear_q,
    output logic            discard_q,
    output logic            trigger_q,
    // front panel control
    output logic            remote_q,
    output logic            keys_enable_q,
    output logic            local_key_enable_q
);
    import sevr_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // ****************************************
    // event sources
    // ****************************************
    logic [7:0] se_set;
    logic [7:0] meas_set;
    logic [7:0] probe_set;
    logic       qerr_any;
    logic       done_fire;
    logic       done_pending_q;
    logic       done_pending_d;

    assign qerr_any = oq_read_empty || oq_overflow ||
                      oq_data_lost || cmd_while_data;
    // completion waits for every earlier message to finish
    assign done_fire = (done_pending_q || complete_cmd) && prior_done;
    assign done_pending_d = (done_pending_q || complete_cmd) && !prior_done;

    assign se_set = {power_restored, 1'b0, cmd_error, exec_error,
                     1'b0, qerr_any, 1'b0, done_fire};
    assign meas_set = {1'b0, out_of_range_fault, measurement_fault,
                       comparator_high, comparator_in_band,
                       comparator_low, conversion_done,
                       measurement_done};
    assign probe_set = {4'h0, voltage_monitor_fault,
                        current_monitor_fault,
                        contact_fault_high_side,
                        contact_fault_low_side};

    // ****************************************
    // event registers
    // ****************************************
    logic [7:0] se_flags;
    logic [7:0] se_mask;
    logic [7:0] meas_flags;
    logic [7:0] meas_mask;
    logic [7:0] probe_flags;
    logic [7:0] probe_mask;
    logic       esb;
    logic       meas_sum;
    logic       probe_sum;

    // power-on leaves only the power flag standing
    sevr_event_reg #(
        .W     (EVT_W),
        .VALID (SE_VALID),
        .RST   (SE_RST),
        .MRST  (MASK_RST)
    ) u_standard (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .set_bits   (se_set),
        .clear      (cls_cmd || standard_event_query),
        .mask_we    (standard_mask_write),
        .mask_wdata (wr_data),
        .flags_q    (se_flags),
        .mask_q     (se_mask),
        .summary    (esb)
    );

    sevr_event_reg #(
        .W     (EVT_W),
        .VALID (MEAS_VALID),
        .RST   (EVT_RST),
        .MRST  (MASK_RST)
    ) u_measurement (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .set_bits   (meas_set),
        .clear      (cls_cmd || measurement_event_query),
        .mask_we    (measurement_mask_write),
        .mask_wdata (wr_data),
        .flags_q    (meas_flags),
        .mask_q     (meas_mask),
        .summary    (meas_sum)
    );

    sevr_event_reg #(
        .W     (EVT_W),
        .VALID (PROBE_VALID),
        .RST   (EVT_RST),
        .MRST  (MASK_RST)
    ) u_probe_fault (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .set_bits   (probe_set),
        .clear      (cls_cmd || probe_fault_event_query),
        .mask_we    (probe_fault_mask_write),
        .mask_wdata (wr_data),
        .flags_q    (probe_flags),
        .mask_q     (probe_mask),
        .summary    (probe_sum)
    );

    // ****************************************
    // status byte and service request
    // ****************************************
    logic [7:0] sre_q;
    logic [7:0] sre_d;
    logic [7:0] stb_raw;
    logic [7:0] stb_full;
    logic       mss;
    logic       mss_q;
    logic       srq_d;

    // clear status empties the sources, the queue bit stays live
    assign stb_raw = {2'b00, esb, oq_not_empty, 2'b00,
                      probe_sum, meas_sum};
    assign mss = |(stb_raw & sre_q & SB_VALID);
    assign stb_full = stb_raw | ({7'h00, mss} << SB_MSS);
    assign sre_d = sre_write ? wr_data : sre_q;
    // request raised on the summary's rising edge, set beats poll
    assign srq_d = (mss && !mss_q) ||
                   (srq_q && !serial_poll && !cls_cmd);

    // ****************************************
    // query responses
    // ****************************************
    logic [7:0] resp_d;
    logic       resp_v;

    assign resp_v = stb_query || sre_query || standard_event_query ||
                    standard_mask_query || measurement_event_query ||
                    measurement_mask_query || probe_fault_event_query ||
                    probe_fault_mask_query || serial_poll;
    // poll shows the request bit where the query shows the summary
    assign resp_d = serial_poll             ? {1'b0, srq_q, stb_raw[5:0]} :
                    stb_query               ? stb_full :
                    sre_query               ? sre_q :
                    standard_event_query    ? se_flags :
                    standard_mask_query     ? se_mask :
                    measurement_event_query ? meas_flags :
                    measurement_mask_query  ? meas_mask :
                    probe_fault_event_query ? probe_flags :
                    probe_fault_mask_query  ? probe_mask :
                    resp_data_q;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sre_q         <= MASK_RST;
            mss_q         <= 1'b0;
            srq_q         <= 1'b0;
            status_byte_q <= 8'h00;
            done_pending_q <= 1'b0;
            resp_data_q   <= 8'h00;
            resp_valid_q  <= 1'b0;
            oq_clear_q    <= 1'b0;
            discard_q     <= 1'b0;
        end else begin
            sre_q         <= sre_d;
            mss_q         <= mss;
            srq_q         <= srq_d;
            status_byte_q <= stb_full;
            done_pending_q <= done_pending_d;
            resp_data_q   <= resp_d;
            resp_valid_q  <= resp_v;
            oq_clear_q    <= qerr_any || dcl_msg || sdc_msg;
            discard_q     <= cmd_error ||
                             (discard_q && !terminator_seen);
        end
    end

    // ****************************************
    // interface messages
    // ****************************************
    sevr_iface_msg u_iface (
        .sys_clk            (sys_clk),
        .resetn             (resetn),
        .gtl_msg            (gtl_msg),
        .llo_msg            (llo_msg),
        .dcl_msg            (dcl_msg),
        .sdc_msg            (sdc_msg),
        .get_msg            (get_msg),
        .remote_enter       (remote_enter),
        .ren_released       (ren_released),
        .local_key          (local_key),
        .remote_q           (remote_q),
        .keys_enable_q      (keys_enable_q),
        .local_key_enable_q (local_key_enable_q),
        .ibuf_clear_q       (ibuf_clear_q),
        .trigger_q          (trigger_q)
    );

    // ****************************************
    // checks
    // ****************************************
    power_flag_set_a: assert property (
        power_restored |=> se_flags[SE_POWER])
        else $error("power flag not set");
    cmd_err_skip_a: assert property (
        cmd_error |=> se_flags[SE_CMD] && discard_q)
        else $error("command error not flagged or not skipped");
    exec_err_set_a: assert property (exec_error |=> se_flags[SE_EXEC])
        else $error("execution error not flagged");
    query_err_clear_a: assert property (
        qerr_any |=> se_flags[SE_QUERY] && oq_clear_q)
        else $error("query error did not flag and clear queue");
    done_after_prior_a: assert property (
        (complete_cmd && !prior_done)
        |=> !se_flags[SE_DONE] || $past(se_flags[SE_DONE]))
        else $error("completion flagged before prior work ended");
    esb_summary_a: assert property (
        1'b1 |=> status_byte_q[SB_ESB] == $past(|(se_flags & se_mask)))
        else $error("standard summary bit wrong");
    dev_summary_a: assert property (
        1'b1 |=> status_byte_q[SB_MEAS] == $past(|(meas_flags & meas_mask)) &&
                 status_byte_q[SB_PROBE] == $past(|(probe_flags & probe_mask)))
        else $error("device summary bits wrong");
    std_read_clear_a: assert property (
        (standard_event_query && se_set == 8'h00) |=> se_flags == 8'h00)
        else $error("standard events not cleared by query");
    cls_clears_dev_a: assert property (
        (cls_cmd && meas_set == 8'h00 && probe_set == 8'h00)
        |=> meas_flags == 8'h00 && probe_flags == 8'h00)
        else $error("device events not cleared");
    mav_tracks_a: assert property (
        1'b1 |=> status_byte_q[SB_MAV] == $past(oq_not_empty))
        else $error("message available bit wrong");
    srq_on_rise_a: assert property (
        (mss && !mss_q) |=> srq_q ##1
        (srq_q || $past(serial_poll || cls_cmd)))
        else $error("service request not raised");
    dev_clear_a: assert property (
        (dcl_msg || sdc_msg) |=> oq_clear_q && ibuf_clear_q)
        else $error("device clear did not empty buffers");

endmodule

//--- verification/sevr_host_model.sv
// remote controller model: register queries, mask writes, bus messages
`timescale 1ns/1ps
module sevr_host_model (
    // clock
    input  wire logic       sys_clk,
    // answers from the device
    input  wire logic [7:0] resp_data_q,
    input  wire logic       resp_valid_q,
    // requests to the device
    output logic      [8:0] qry,
    output logic      [3:0] wr,
    output logic      [7:0] wr_data,
    output logic      [4:0] msg
);
    // ****************************************
    // request tasks, one strobe edge each
    // ****************************************
    initial begin
        qry     = 9'h000;
        wr      = 4'h0;
        wr_data = 8'h00;
        msg     = 5'h00;
    end
    task automatic ask(input int k, output logic [7:0] d, output logic v);
        @(posedge sys_clk);
        qry <= 9'h001 << k;
        @(posedge sys_clk);
        qry <= 9'h000;
        #1;
        d = resp_data_q;
        v = resp_valid_q;
    endtask
    // only masks are written; event flags have no write path
    task automatic put(input int k, input logic [7:0] d);
        @(posedge sys_clk);
        wr      <= 4'h1 << k;
        wr_data <= d;
        @(posedge sys_clk);
        wr      <= 4'h0;
        wr_data <= ~d; // stale bus value inverted, never left looking valid
        #1;
    endtask
    task automatic send(input int k);
        @(posedge sys_clk);
        msg <= 5'h01 << k;
        @(posedge sys_clk);
        msg <= 5'h00;
        #1;
    endtask
endmodule

//--- verification/tb_status_event_reporting.sv
// self-checking bench for the status and event reporting block
`timescale 1ns/1ps
module tb_status_event_reporting;
    logic        sys_clk;
    logic        resetn;
    logic [23:0] ev;
    logic        prior_done;
    logic        oq_not_empty;
    logic [8:0]  qry;
    logic [3:0]  wr;
    logic [7:0]  wr_data;
    logic [4:0]  msg;
    logic [7:0]  resp_data_q;
    logic [7:0]  status_byte_q;
    logic        resp_valid_q, srq_q, oq_clear_q, ibuf_clear_q, discard_q;
    logic        trigger_q, remote_q, keys_enable_q, local_key_enable_q;
    int          failures;
    int          n_compared;

    sevr_top i_sevr_top (
        .sys_clk(sys_clk), .resetn(resetn), .power_restored(ev[0]),
        .cmd_error(ev[1]), .exec_error(ev[2]), .terminator_seen(ev[3]),
        .complete_cmd(ev[4]), .prior_done(prior_done), .cls_cmd(ev[5]),
        .oq_not_empty(oq_not_empty), .oq_read_empty(ev[6]),
        .oq_overflow(ev[7]), .oq_data_lost(ev[8]), .cmd_while_data(ev[9]),
        .out_of_range_fault(ev[19]), .measurement_fault(ev[18]),
        .comparator_high(ev[17]), .comparator_in_band(ev[16]),
        .comparator_low(ev[15]), .conversion_done(ev[14]),
        .measurement_done(ev[13]), .voltage_monitor_fault(ev[23]),
        .current_monitor_fault(ev[22]), .contact_fault_high_side(ev[21]),
        .contact_fault_low_side(ev[20]), .wr_data(wr_data),
        .sre_write(wr[0]), .standard_mask_write(wr[1]),
        .measurement_mask_write(wr[2]), .probe_fault_mask_write(wr[3]),
        .stb_query(qry[0]), .sre_query(qry[1]),
        .standard_event_query(qry[2]), .standard_mask_query(qry[3]),
        .measurement_event_query(qry[4]), .measurement_mask_query(qry[5]),
        .probe_fault_event_query(qry[6]), .probe_fault_mask_query(qry[7]),
        .serial_poll(qry[8]), .gtl_msg(msg[0]), .llo_msg(msg[1]),
        .dcl_msg(msg[2]), .sdc_msg(msg[3]), .get_msg(msg[4]),
        .remote_enter(ev[10]), .ren_released(ev[11]), .local_key(ev[12]),
        .resp_data_q(resp_data_q), .resp_valid_q(resp_valid_q),
        .status_byte_q(status_byte_q), .srq_q(srq_q),
        .oq_clear_q(oq_clear_q), .ibuf_clear_q(ibuf_clear_q),
        .discard_q(discard_q), .trigger_q(trigger_q), .remote_q(remote_q),
        .keys_enable_q(keys_enable_q),
        .local_key_enable_q(local_key_enable_q)
    );
    sevr_host_model i_sevr_host_model (
        .sys_clk(sys_clk), .resp_data_q(resp_data_q),
        .resp_valid_q(resp_valid_q), .qry(qry), .wr(wr),
        .wr_data(wr_data), .msg(msg)
    );

    // ****************************************
    // shared helpers
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic fire(input logic [23:0] m);
        @(posedge sys_clk);
        ev <= m;
        @(posedge sys_clk);
        ev <= 24'h000000;
        #1;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input int k, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        i_sevr_host_model.ask(k, d, v);
        check("answer strobe", {7'h00, v}, 8'h01);
        check("answer data", d, exp);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic run_power();
        rd(2, 8'h80);
        rd(2, 8'h00);
        fire(24'h000001);
        rd(2, 8'h80);
        check("keys enabled", {7'h00, keys_enable_q}, 8'h01);
    endtask
    task automatic run_std();
        fire(24'h000002);
        check("discard", {7'h00, discard_q}, 8'h01);
        fire(24'h000004);
        fire(24'h000008);
        check("discard end", {7'h00, discard_q}, 8'h00);
        for (int i = 6; i < 10; i++) begin
            fire(24'h000001 << i);
            check("queue clear", {7'h00, oq_clear_q}, 8'h01);
        end
        fire(24'h000010);
        // completion must wait for earlier work, so bit 0 stays low
        rd(2, 8'h34);
        @(posedge sys_clk) prior_done <= 1'b1;
        wait_n(2);
        rd(2, 8'h01);
    endtask
    task automatic run_summary();
        i_sevr_host_model.put(1, 8'h20);
        i_sevr_host_model.put(0, 8'h20);
        fire(24'h000002);
        wait_n(1);
        check("status", status_byte_q, 8'h60);
        wait_n(1);
        check("srq", {7'h00, srq_q}, 8'h01);
        rd(8, 8'h60);
        wait_n(1);
        check("srq polled", {7'h00, srq_q}, 8'h00);
        fire(24'h000008);
        rd(0, 8'h60);
        @(posedge sys_clk) oq_not_empty <= 1'b1;
        fire(24'h000020);
        wait_n(1);
        check("status cls", status_byte_q, 8'h10);
        rd(3, 8'h20);
        rd(1, 8'h20);
    endtask
    task automatic run_device();
        i_sevr_host_model.put(2, 8'h80);
        i_sevr_host_model.put(3, 8'hf0);
        fire(24'hffe000);
        wait_n(1);
        check("status unused", status_byte_q, 8'h10);
        rd(4, 8'h7f);
        rd(6, 8'h0f);
        rd(4, 8'h00);
        i_sevr_host_model.put(2, 8'h01);
        fire(24'h002000);
        wait_n(1);
        check("status meas", status_byte_q, 8'h11);
        i_sevr_host_model.put(3, 8'h08);
        fire(24'h800000);
        wait_n(1);
        check("status probe", status_byte_q, 8'h13);
        rd(5, 8'h01);
        rd(7, 8'h08);
        fire(24'h000020);
        rd(4, 8'h00);
        rd(6, 8'h00);
    endtask
    task automatic run_iface();
        fire(24'h000400);
        check("remote", {7'h00, remote_q}, 8'h01);
        i_sevr_host_model.send(1);
        check("local key", {7'h00, local_key_enable_q}, 8'h00);
        fire(24'h001000);
        check("remote kept", {7'h00, remote_q}, 8'h01);
        i_sevr_host_model.send(0);
        check("remote left", {7'h00, remote_q}, 8'h00);
        check("keys locked", {7'h00, keys_enable_q}, 8'h00);
        fire(24'h000800);
        for (int k = 2; k < 4; k++) begin
            i_sevr_host_model.send(k);
            check("ibuf clear", {7'h00, ibuf_clear_q}, 8'h01);
            check("oq clear", {7'h00, oq_clear_q}, 8'h01);
        end
        i_sevr_host_model.send(4);
        check("trigger", {7'h00, trigger_q}, 8'h01);
        wait_n(1);
        check("trigger once", {7'h00, trigger_q}, 8'h00);
    endtask

    // ****************************************
    // clock, sequence and verdict
    // ****************************************
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // hang guard, far beyond the hundred or so cycles the run needs
    initial begin
        #200000;
        failures++;
        close_out();
    end
    initial begin
        resetn       = 1'b0;
        ev           = 24'h000000;
        prior_done   = 1'b0;
        oq_not_empty = 1'b0;
        failures     = 0;
        n_compared   = 0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        run_power();
        run_std();
        run_summary();
        run_device();
        run_iface();
        close_out();
    end
endmodule
